/* File: src/mac_regs.svh */
// register offsets, field positions and reset values of the multiply-accumulate core
`ifndef MAC_REGS_SVH
`define MAC_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define MAC_CTRL_OFFSET     12'h000
`define MAC_STATUS_OFFSET   12'h004

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define MAC_CTRL_PRELOAD_EN 0
`define MAC_CTRL_UPPER_LSB  16
`define MAC_CTRL_UPPER_W    16
`define MAC_CTRL_RESET      32'h00000000
`define MAC_STATUS_OVF      0
`define MAC_CLEAR_NONE      4

`endif

/* File: src/mac_pkg.sv */
// shared types and the clear-selection decode of the multiply-accumulate core
package mac_pkg;

	typedef logic [31:0] word_t;
	typedef logic [3:0]  quad_t;

	// selected clear (4 = none) merged with the global reset
	function automatic logic pick_clear(input quad_t bus, input int sel, input logic rstn);
		logic hit;
		hit = (sel < 4) ? bus[2'(sel)] : 1'b0;
		return hit | ~rstn;
	endfunction

endpackage

/* File: src/multiply_accumulate_core.sv */
// multiply-accumulate datapath with selectable clocks, clears and latency, plus APB control
//
// Functional notes
// - Load-select in add mode loads the product into the accumulator.
// - Load-select in subtract mode loads the negated product.
// - Load-select replaces feedback by zero or preload upper value with zeros.
// - Add-subtract select high adds, low subtracts.
// - Sign-A high: operand A signed two's complement, else unsigned.
// - Sign-B high: operand B signed two's complement, else unsigned.
// - Four active-high asynchronous clears, each acting only on its assigned registers.
// - Four clock inputs; each register picks one by configuration.
// - Each clock has an enable; low enable holds its registers, except the preload control synchronizer on the output clock.
// - Accumulator output is always registered.
// - Output extra latency 0-8 or 12, selectable clock and clear.
// - Multiplier extra latency 0-8 or 12, on the product register clock.
// - Optional A and B input registers with selectable clock and clear.
// - Optional product register with selectable clock and clear.
// - Load-select has optional input and pipeline registers, each selectable.
// - Sign-B has optional input and pipeline registers, each selectable.
// - Shift-out chains give the registered A and B operands.
// - Overflow output flags accumulator overflow.
// - Result width equals the configured result width.
// - Operand widths configurable from 1 to 256; result width from 16, and at least the A plus B width less one.
// - Exactly one multiplier.

`include "mac_regs.svh"

// ----------------------------------------
// optional register with selected clock, enable and clear
// ----------------------------------------
module mac_opt_stage #(
	parameter int W       = 1,
	parameter int USE     = 1,
	parameter int CLK_SEL = 0,
	parameter int CLR_SEL = 4
) (
	input  wire logic [3:0]   clk_bus,  // the four clocks
	input  wire logic [3:0]   ena_bus,  // their enables
	input  wire logic [3:0]   clr_bus,  // the four clears
	input  wire logic         presetn,  // global reset, low active
	input  wire logic [W-1:0] d,        // stage input
	output logic      [W-1:0] q         // stage output
);
	generate
		if (USE != 0) begin : g_reg
			logic         clk_s;
			logic         clr_s;
			logic [W-1:0] r;
			logic [W-1:0] next_r;
			assign clk_s = clk_bus[CLK_SEL];
			assign clr_s = mac_pkg::pick_clear(clr_bus, CLR_SEL, presetn);
			always_comb begin
				next_r = ena_bus[CLK_SEL] ? d : r;
			end
			always_ff @(posedge clk_s or posedge clr_s) begin
				if (clr_s)
					r <= '0;
				else
					r <= next_r;
			end
			assign q = r;
		end else begin : g_wire
			assign q = d;
		end
	endgenerate
endmodule

// ----------------------------------------
// top level
// ----------------------------------------
module multiply_accumulate_core #(
	parameter int WIDTH_A  = 16,
	parameter int WIDTH_B  = 16,
	parameter int WIDTH_R  = 40,
	parameter int A_REG    = 1, parameter int A_CLK = 0, parameter int A_CLR = 0,
	parameter int B_REG    = 1, parameter int B_CLK = 0, parameter int B_CLR = 0,
	parameter int SA_REG   = 1, parameter int SA_CLK = 0, parameter int SA_CLR = 0,
	parameter int SAP_REG  = 1, parameter int SAP_CLK = 0, parameter int SAP_CLR = 0,
	parameter int SB_REG   = 1, parameter int SB_CLK = 0, parameter int SB_CLR = 0,
	parameter int SBP_REG  = 1, parameter int SBP_CLK = 0, parameter int SBP_CLR = 0,
	parameter int LD_REG   = 1, parameter int LD_CLK = 0, parameter int LD_CLR = 0,
	parameter int LDP_REG  = 1, parameter int LDP_CLK = 0, parameter int LDP_CLR = 0,
	parameter int MUL_REG  = 1, parameter int MUL_CLK = 0, parameter int MUL_CLR = 0,
	parameter int MUL_LAT  = 0,
	parameter int OUT_CLK  = 0, parameter int OUT_CLR = 0,
	parameter int OUT_LAT  = 0
) (
	input  wire logic               pclk,          // APB clock
	input  wire logic               presetn,       // APB and global reset, low active
	input  wire logic [11:0]        paddr,         // APB address
	input  wire logic               psel,          // APB select
	input  wire logic               penable,       // APB enable
	input  wire logic               pwrite,        // APB direction
	input  wire logic [31:0]        pwdata,        // APB write data
	output logic      [31:0]        prdata,        // APB read data
	output logic                    pready,        // APB ready
	output logic                    pslverr,       // APB error
	input  wire logic               clk_0,         // datapath clock 0
	input  wire logic               clk_1,         // datapath clock 1
	input  wire logic               clk_2,         // datapath clock 2
	input  wire logic               clk_3,         // datapath clock 3
	input  wire logic               clock_gate_0,  // enable of clock 0
	input  wire logic               clock_gate_1,  // enable of clock 1
	input  wire logic               clock_gate_2,  // enable of clock 2
	input  wire logic               clock_gate_3,  // enable of clock 3
	input  wire logic               async_clear_0, // clear 0, high active
	input  wire logic               async_clear_1, // clear 1, high active
	input  wire logic               async_clear_2, // clear 2, high active
	input  wire logic               async_clear_3, // clear 3, high active
	input  wire logic [WIDTH_A-1:0] operand_a,     // multiplier operand A
	input  wire logic [WIDTH_B-1:0] operand_b,     // multiplier operand B
	input  wire logic               sign_a,        // A is signed
	input  wire logic               sign_b,        // B is signed
	input  wire logic               add_sub,       // 1 add, 0 subtract
	input  wire logic               load_sel,      // start new accumulation
	output logic      [WIDTH_R-1:0] result,        // accumulated result
	output logic                    overflow,      // accumulator overflow
	output logic      [WIDTH_A-1:0] shift_a,       // registered A chain
	output logic      [WIDTH_B-1:0] shift_b        // registered B chain
);
	// operand widths of 1 to 256 set by parameters; WIDTH_R must be at least 16 and at least PW-1
	localparam int PW = WIDTH_A + WIDTH_B;
	localparam int UW = `MAC_CTRL_UPPER_W;

	logic [3:0] clk_bus;
	logic [3:0] ena_bus;
	logic [3:0] clr_bus;
	assign clk_bus = {clk_3, clk_2, clk_1, clk_0};
	assign ena_bus = {clock_gate_3, clock_gate_2, clock_gate_1, clock_gate_0};
	assign clr_bus = {async_clear_3, async_clear_2, async_clear_1, async_clear_0};

	// ----------------------------------------
	// input and control registers
	// ----------------------------------------
	logic [WIDTH_A-1:0] a_q;
	logic [WIDTH_B-1:0] b_q;
	logic               sa_q, sa_p, sb_q, sb_p, ld_q, ld_p;

	mac_opt_stage #(.W(WIDTH_A), .USE(A_REG), .CLK_SEL(A_CLK), .CLR_SEL(A_CLR)) u_a (
		.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
		.d(operand_a), .q(a_q));
	mac_opt_stage #(.W(WIDTH_B), .USE(B_REG), .CLK_SEL(B_CLK), .CLR_SEL(B_CLR)) u_b (
		.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
		.d(operand_b), .q(b_q));
	// sign-A follows the same two-stage pattern as sign-B
	mac_opt_stage #(.W(1), .USE(SA_REG), .CLK_SEL(SA_CLK), .CLR_SEL(SA_CLR)) u_sa (
		.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
		.d(sign_a), .q(sa_q));
	mac_opt_stage #(.W(1), .USE(SAP_REG), .CLK_SEL(SAP_CLK), .CLR_SEL(SAP_CLR)) u_sap (
		.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
		.d(sa_q), .q(sa_p));
	mac_opt_stage #(.W(1), .USE(SB_REG), .CLK_SEL(SB_CLK), .CLR_SEL(SB_CLR)) u_sb (
		.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
		.d(sign_b), .q(sb_q));
	mac_opt_stage #(.W(1), .USE(SBP_REG), .CLK_SEL(SBP_CLK), .CLR_SEL(SBP_CLR)) u_sbp (
		.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
		.d(sb_q), .q(sb_p));
	mac_opt_stage #(.W(1), .USE(LD_REG), .CLK_SEL(LD_CLK), .CLR_SEL(LD_CLR)) u_ld (
		.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
		.d(load_sel), .q(ld_q));
	mac_opt_stage #(.W(1), .USE(LDP_REG), .CLK_SEL(LDP_CLK), .CLR_SEL(LDP_CLR)) u_ldp (
		.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
		.d(ld_q), .q(ld_p));

	// shift-out chains are the registered operands
	assign shift_a = a_q;
	assign shift_b = b_q;

	// ----------------------------------------
	// the single multiplier
	// ----------------------------------------
	logic signed [WIDTH_A:0] a_ext;
	logic signed [WIDTH_B:0] b_ext;
	logic signed [PW+1:0]    prod_full;
	logic        [PW-1:0]    mul_q;

	// A extended by its sign only when signed
	assign a_ext = {sa_q & a_q[WIDTH_A-1], a_q};
	// B extended by its sign only when signed
	assign b_ext = {sb_q & b_q[WIDTH_B-1], b_q};
	// one multiplier; the extra bit keeps mixed signs exact
	assign prod_full = a_ext * b_ext;

	mac_opt_stage #(.W(PW), .USE(MUL_REG), .CLK_SEL(MUL_CLK), .CLR_SEL(MUL_CLR)) u_mul (
		.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
		.d(prod_full[PW-1:0]), .q(mul_q));

	// extra multiplier latency on the product register clock
	logic [PW:0] mchain [0:MUL_LAT];
	assign mchain[0] = {sa_p | sb_p, mul_q}; // sign pipe runs beside the product register
	genvar gi;
	generate
		for (gi = 0; gi < MUL_LAT; gi++) begin : g_mlat
			mac_opt_stage #(.W(PW+1), .USE(1), .CLK_SEL(MUL_CLK), .CLR_SEL(MUL_CLR)) u_st (
				.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
				.d(mchain[gi]), .q(mchain[gi+1]));
		end
	endgenerate

	// ----------------------------------------
	// accumulator
	// ----------------------------------------
	logic               acc_clk, acc_clr, acc_ena;
	logic [WIDTH_R-1:0] acc, next_acc, fb, preload_vec;
	logic               ovf, next_ovf, ovf_now, prod_signed;
	logic [WIDTH_R:0]   prod_ext, fb_ext, sum;
	logic [UW:0]        cfg_meta, cfg_sync;
	logic [31:0]        ctrl;

	assign acc_clk = clk_bus[OUT_CLK];
	assign acc_ena = ena_bus[OUT_CLK];
	assign acc_clr = mac_pkg::pick_clear(clr_bus, OUT_CLR, presetn);
	assign prod_signed = mchain[MUL_LAT][PW];

	// preload control moved into the accumulator clock; quasi-static by contract
	always_ff @(posedge acc_clk or posedge acc_clr) begin
		if (acc_clr) begin
			cfg_meta <= '0;
			cfg_sync <= '0;
		end else begin
			cfg_meta <= {ctrl[`MAC_CTRL_UPPER_LSB +: UW], ctrl[`MAC_CTRL_PRELOAD_EN]};
			cfg_sync <= cfg_meta;
		end
	end

	// add or subtract the product, with overflow from one spare bit
	always_comb begin
		// base value of a new accumulation
		preload_vec = cfg_sync[0] ? {cfg_sync[UW:1], {(WIDTH_R-UW){1'b0}}} : '0;
		fb = ld_p ? preload_vec : acc;
		prod_ext = {{(WIDTH_R+1-PW){prod_signed & mchain[MUL_LAT][PW-1]}}, mchain[MUL_LAT][PW-1:0]};
		fb_ext = {prod_signed & fb[WIDTH_R-1], fb};
		sum = add_sub ? (fb_ext + prod_ext) : (fb_ext - prod_ext);
		// signed sign change or unsigned carry/borrow
		ovf_now = prod_signed ? (sum[WIDTH_R] ^ sum[WIDTH_R-1]) : sum[WIDTH_R];
		// load or accumulate on enabled edges
		next_acc = acc_ena ? sum[WIDTH_R-1:0] : acc;
		next_ovf = acc_ena ? (ovf_now | (ovf & ~ld_p)) : ovf;
	end

	always_ff @(posedge acc_clk or posedge acc_clr) begin
		if (acc_clr) begin
			acc <= '0;
			ovf <= 1'b0;
		end else begin
			acc <= next_acc;
			ovf <= next_ovf;
		end
	end

	// extra output latency on the output clock
	logic [WIDTH_R:0] ochain [0:OUT_LAT];
	assign ochain[0] = {ovf, acc};
	generate
		for (gi = 0; gi < OUT_LAT; gi++) begin : g_olat
			mac_opt_stage #(.W(WIDTH_R+1), .USE(1), .CLK_SEL(OUT_CLK), .CLR_SEL(OUT_CLR)) u_st (
				.clk_bus(clk_bus), .ena_bus(ena_bus), .clr_bus(clr_bus), .presetn(presetn),
				.d(ochain[gi]), .q(ochain[gi+1]));
		end
	endgenerate
	assign result   = ochain[OUT_LAT][WIDTH_R-1:0];
	assign overflow = ochain[OUT_LAT][WIDTH_R];

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	function automatic logic reg_hit(input logic [11:0] a);
		return (a == `MAC_CTRL_OFFSET) || (a == `MAC_STATUS_OFFSET);
	endfunction

	logic [31:0] next_ctrl, next_prdata;
	logic        ovf_meta, ovf_sync;

	// overflow level brought into pclk for status reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_meta <= 1'b0;
			ovf_sync <= 1'b0;
		end else begin
			ovf_meta <= overflow;
			ovf_sync <= ovf_meta;
		end
	end

	// read data captured in setup so the access needs no wait
	always_comb begin
		next_ctrl = ctrl;
		next_prdata = prdata;
		if (psel && penable && pwrite && paddr == `MAC_CTRL_OFFSET)
			next_ctrl = pwdata;
		if (psel && !penable && !pwrite) begin
			next_prdata = '0;
			if (paddr == `MAC_CTRL_OFFSET)
				next_prdata = ctrl;
			else if (paddr == `MAC_STATUS_OFFSET)
				next_prdata[`MAC_STATUS_OVF] = ovf_sync;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl   <= `MAC_CTRL_RESET;
			prdata <= '0;
		end else begin
			ctrl   <= next_ctrl;
			prdata <= next_prdata;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~reg_hit(paddr); // unmapped answers with an error

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_load_add;
		@(posedge acc_clk) disable iff (acc_clr)
		(acc_ena && ld_p && add_sub) |=> (acc == $past(preload_vec) + $past(prod_ext[WIDTH_R-1:0]));
	endproperty
	a_load_add: assert property (p_load_add) else $error("load in add mode wrong");

	property p_load_sub;
		@(posedge acc_clk) disable iff (acc_clr)
		(acc_ena && ld_p && !add_sub) |=> (acc == $past(preload_vec) - $past(prod_ext[WIDTH_R-1:0]));
	endproperty
	a_load_sub: assert property (p_load_sub) else $error("load in subtract mode wrong");

	property p_load_base;
		@(posedge acc_clk) disable iff (acc_clr)
		(ld_p && !cfg_sync[0]) |-> (fb == '0);
	endproperty
	a_load_base: assert property (p_load_base) else $error("load base not zero");

	property p_accum_add;
		@(posedge acc_clk) disable iff (acc_clr)
		(acc_ena && !ld_p && add_sub) |=> (acc == $past(acc) + $past(prod_ext[WIDTH_R-1:0]));
	endproperty
	a_accum_add: assert property (p_accum_add) else $error("accumulate add wrong");

	property p_accum_sub;
		@(posedge acc_clk) disable iff (acc_clr)
		(acc_ena && !ld_p && !add_sub) |=> (acc == $past(acc) - $past(prod_ext[WIDTH_R-1:0]));
	endproperty
	a_accum_sub: assert property (p_accum_sub) else $error("accumulate subtract wrong");

	property p_hold;
		@(posedge acc_clk) disable iff (acc_clr)
		!acc_ena |=> $stable(acc) && $stable(ovf);
	endproperty
	a_hold: assert property (p_hold) else $error("accumulator moved while disabled");

	property p_unsigned_mul;
		@(posedge acc_clk) disable iff (acc_clr)
		(!sa_q && !sb_q) |-> (prod_full[PW-1:0] == PW'({{WIDTH_B{1'b0}}, a_q} * {{WIDTH_A{1'b0}}, b_q}));
	endproperty
	a_unsigned_mul: assert property (p_unsigned_mul) else $error("unsigned product wrong");

	property p_signed_mul;
		@(posedge acc_clk) disable iff (acc_clr)
		(sa_q && sb_q) |-> ($signed(prod_full[PW-1:0]) == $signed(a_q) * $signed(b_q));
	endproperty
	a_signed_mul: assert property (p_signed_mul) else $error("signed product wrong");

	property p_clear;
		@(posedge acc_clk) acc_clr ##1 acc_clr |-> (acc == '0) && !ovf;
	endproperty
	a_clear: assert property (p_clear) else $error("accumulator not cleared");

	property p_ovf_flag;
		@(posedge acc_clk) disable iff (acc_clr)
		(acc_ena && ovf_now) |=> ovf;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow not flagged");

	c_load_add:  cover property (@(posedge acc_clk) disable iff (acc_clr) acc_ena && ld_p && add_sub);
	c_accum_sub: cover property (@(posedge acc_clk) disable iff (acc_clr) acc_ena && !ld_p && !add_sub);
	c_overflow:  cover property (@(posedge acc_clk) disable iff (acc_clr) !ovf ##1 ovf);
	c_apb_write: cover property (@(posedge pclk) disable iff (!presetn) psel && penable && pwrite);

endmodule

/* File: verif/mac_user_model.sv */
// user-side model presenting operands and controls to the multiply-accumulate core
module mac_user_model #(
	parameter int WA = 16,
	parameter int WB = 16
) (
	input  wire logic          clk,       // datapath clock
	input  wire logic          gate,      // enable of that clock
	input  wire logic [WA-1:0] req_a,     // requested operand A
	input  wire logic [WB-1:0] req_b,     // requested operand B
	input  wire logic          req_sa,    // requested sign of A
	input  wire logic          req_sb,    // requested sign of B
	input  wire logic          req_ld,    // requested load
	input  wire logic          req_add,   // requested add, low subtract
	output logic      [WA-1:0] operand_a, // operand A to the core
	output logic      [WB-1:0] operand_b, // operand B to the core
	output logic               sign_a,    // sign of A
	output logic               sign_b,    // sign of B
	output logic               load_sel,  // load select
	output logic               add_sub    // add select, delayed
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] add_pipe;
	logic [1:0] next_add_pipe;

	assign operand_a = req_a;
	assign operand_b = req_b;
	assign sign_a    = req_sa;
	assign sign_b    = req_sb;
	assign load_sel  = req_ld;

	// add select is unregistered in the core, so it must trail its operands by two enabled edges
	always_comb next_add_pipe = gate ? {add_pipe[0], req_add} : add_pipe;
	always_ff @(posedge clk) add_pipe <= next_add_pipe;
	assign add_sub = add_pipe[1];
endmodule

/* File: verif/tb_top.sv */
// self-checking bench of the multiply-accumulate core
`include "mac_regs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready, pslverr, overflow, sign_a, sign_b, load_sel, add_sub;
	logic [3:0]  gates = 4'hF;
	logic [3:0]  clrs = 4'h0;
	logic [15:0] ra = 16'h0000, rb = 16'h0000, operand_a, operand_b, shift_a, shift_b;
	logic        rsa = 1'b0, rsb = 1'b0, rld = 1'b0, radd = 1'b1;
	logic [39:0] result;
	logic [39:0] exp_acc = 40'h0000000000;
	logic [39:0] pre_val = 40'h0000000000;
	logic [31:0] rd;
	logic        er;
	int          err_total = 0;
	int          n_tests = 0;

	multiply_accumulate_core dut_u (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clk_0(pclk), .clk_1(pclk), .clk_2(pclk), .clk_3(pclk),
		.clock_gate_0(gates[0]), .clock_gate_1(gates[1]), .clock_gate_2(gates[2]), .clock_gate_3(gates[3]),
		.async_clear_0(clrs[0]), .async_clear_1(clrs[1]), .async_clear_2(clrs[2]), .async_clear_3(clrs[3]),
		.operand_a(operand_a), .operand_b(operand_b), .sign_a(sign_a), .sign_b(sign_b), .add_sub(add_sub),
		.load_sel(load_sel), .result(result), .overflow(overflow), .shift_a(shift_a), .shift_b(shift_b));

	mac_user_model user_u (
		.clk(pclk), .gate(gates[0]), .req_a(ra), .req_b(rb), .req_sa(rsa), .req_sb(rsb), .req_ld(rld),
		.req_add(radd), .operand_a(operand_a), .operand_b(operand_b), .sign_a(sign_a), .sign_b(sign_b),
		.load_sel(load_sel), .add_sub(add_sub));

	// ----------------------------------------
	// clock and shared tasks
	// ----------------------------------------
	initial begin
		forever #20 pclk = ~pclk;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [39:0] e, input logic [39:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", name, e, g);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_total++;
			wrap_up();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// present one operand pair and update the expected sum
	task automatic mac_op(input logic [15:0] a, input logic [15:0] b, input logic sa, input logic sb,
			input logic ld, input logic as);
		logic signed [39:0] xa;
		logic signed [39:0] xb;
		logic [39:0]        base;
		xa = $signed({sa & a[15], a});
		xb = $signed({sb & b[15], b});
		@(posedge pclk);
		ra <= a;
		rb <= b;
		rsa <= sa;
		rsb <= sb;
		rld <= ld;
		radd <= as;
		base = ld ? pre_val : exp_acc;
		exp_acc = as ? base + 40'(xa * xb) : base - 40'(xa * xb);
	endtask

	// idle pairs add nothing; three edges bring the last product to the output
	task automatic flush();
		repeat (3) mac_op(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1);
		#1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		chk("result", 40'h0000000000, result);
		chk("overflow", 40'h0, overflow);
		apb(1'b0, `MAC_CTRL_OFFSET, 32'h00000000);
		chk("ctrl reset", 40'(`MAC_CTRL_RESET), 40'(rd));
		apb(1'b1, `MAC_CTRL_OFFSET, 32'h12340001);
		apb(1'b0, `MAC_CTRL_OFFSET, 32'h00000000);
		chk("ctrl", 40'h0012340001, 40'(rd));
		chk("mapped err", 40'h0, 40'(er));
		apb(1'b1, `MAC_CTRL_OFFSET, 32'h00000000);
		apb(1'b1, `MAC_STATUS_OFFSET, 32'hFFFFFFFF);
		apb(1'b0, `MAC_STATUS_OFFSET, 32'h00000000);
		chk("status", 40'h0, 40'(rd));
		apb(1'b0, 12'h008, 32'h00000000);
		chk("unmapped err", 40'h1, 40'(er));
		chk("unmapped data", 40'h0, 40'(rd));
		$display("test regs done");
	endtask

	task automatic t_accum();
		mac_op(16'h0003, 16'h0004, 1'b0, 1'b0, 1'b1, 1'b1);
		mac_op(16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1);
		#1;
		chk("shift_a", 40'h3, 40'(shift_a));
		chk("shift_b", 40'h4, 40'(shift_b));
		mac_op(16'h0005, 16'h0006, 1'b0, 1'b0, 1'b0, 1'b1);
		mac_op(16'h0002, 16'h0007, 1'b0, 1'b0, 1'b0, 1'b0);
		mac_op(16'hFFFE, 16'h0003, 1'b1, 1'b0, 1'b0, 1'b1);
		mac_op(16'hFFFE, 16'h0003, 1'b0, 1'b0, 1'b0, 1'b1);
		mac_op(16'h0003, 16'hFFFF, 1'b0, 1'b1, 1'b0, 1'b0);
		flush();
		chk("sum", exp_acc, result);
		chk("overflow", 40'h0, overflow);
		mac_op(16'h0002, 16'h0005, 1'b0, 1'b0, 1'b1, 1'b0);
		flush();
		chk("load negated", 40'hFFFFFFFFF6, result);
		$display("test accum done");
	endtask

	task automatic t_gate();
		mac_op(16'h0002, 16'h0003, 1'b0, 1'b0, 1'b1, 1'b1);
		flush();
		@(posedge pclk);
		gates[0] <= 1'b0;
		ra <= 16'h0007;
		rb <= 16'h0007;
		rld <= 1'b1;
		repeat (4) @(posedge pclk);
		#1;
		chk("held", 40'h6, result);
		@(posedge pclk);
		gates[0] <= 1'b1;
		ra <= 16'h0000;
		rb <= 16'h0000;
		rld <= 1'b0;
		flush();
		chk("resumed", 40'h6, result);
		$display("test gate done");
	endtask

	task automatic t_clear();
		mac_op(16'h0010, 16'h0010, 1'b0, 1'b0, 1'b1, 1'b1);
		flush();
		// a non-zero A proves that clear 1 leaves A and the accumulator alone while clears 0 and 1 together clear both
		@(posedge pclk);
		clrs <= 4'h2;
		ra <= 16'h0055;
		@(posedge pclk);
		#5;
		chk("other clear", 40'h100, result);
		chk("other clear a", 40'h55, 40'(shift_a));
		@(posedge pclk);
		clrs <= 4'h3;
		#5;
		chk("cleared", 40'h0, result);
		chk("shift cleared", 40'h0, 40'(shift_a));
		exp_acc = 40'h0000000000;
		@(posedge pclk);
		clrs <= 4'h0;
		ra <= 16'h0000;
		$display("test clear done");
	endtask

	task automatic t_preload_ovf();
		// preload leaves room for one product, the second one carries out
		apb(1'b1, `MAC_CTRL_OFFSET, 32'hFF000001);
		pre_val = 40'hFF00000000;
		repeat (4) @(posedge pclk);
		mac_op(16'hFFFF, 16'hFFFF, 1'b0, 1'b0, 1'b1, 1'b1);
		flush();
		chk("preload", exp_acc, result);
		chk("no overflow", 40'h0, overflow);
		mac_op(16'hFFFF, 16'hFFFF, 1'b0, 1'b0, 1'b0, 1'b1);
		flush();
		chk("wrapped", exp_acc, result);
		chk("overflow set", 40'h1, overflow);
		repeat (4) @(posedge pclk);
		apb(1'b0, `MAC_STATUS_OFFSET, 32'h00000000);
		chk("status ovf", 40'h1, 40'(rd[`MAC_STATUS_OVF]));
		apb(1'b1, `MAC_CTRL_OFFSET, 32'h00000000);
		pre_val = 40'h0000000000;
		repeat (4) @(posedge pclk);
		mac_op(16'h0001, 16'h0001, 1'b0, 1'b0, 1'b1, 1'b1);
		flush();
		chk("restart", 40'h1, result);
		chk("overflow restart", 40'h0, overflow);
		$display("test preload overflow done");
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		t_regs();
		t_accum();
		t_gate();
		t_clear();
		t_preload_ovf();
		wrap_up();
	end

	initial begin
		#200us;
		err_total++;
		wrap_up();
	end
endmodule
